// ==== verilog/spp_port.sv ====
// Summary of operation
// - modem enable rises after ring seen
// - receive only from the receive-data line
// - transmit idle low, spacing high
// - one start, eight data, one stop; a sync transmit sends the eight data bits alone
// - eight selectable bit rates
// - sync enable addresses devices and printer
// - clock line, enable, transmit address peripheral
// - in printer mode without sync mode, handshake high permits, low halts output
`timescale 1ns/1ps
`default_nettype none
module spp_port (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic [2:0] i_baud_sel,
  input wire logic i_sync_mode,
  input wire logic i_printer_mode,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic [7:0] i_tx_data,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_frame_err,
  input wire logic i_ring,
  input wire logic i_rx_line,
  input wire logic i_clock_handshake_line,
  output logic o_clock_handshake_line,
  output logic o_clock_handshake_line_oe,
  output logic o_tx_line,
  output logic o_modem_enable_out,
  output logic o_sync_device_enable
);
  typedef enum logic [1:0] {SPP_IDLE, SPP_START, SPP_DATA, SPP_STOP} spp_state_type;

  spp_stream_if #(.WIDTH(8)) txq ();

  logic [1:0] ring_s;
  logic [1:0] rx_s;
  logic [1:0] hs_s;
  logic [19:0] bit_cycles;
  spp_state_type tx_state;
  logic [19:0] tx_cnt;
  logic [2:0] tx_idx;
  logic [7:0] tx_sh;
  logic tx_sync;
  logic in_ready;
  spp_state_type rx_state;
  logic [19:0] rx_cnt;
  logic [2:0] rx_idx;
  logic [7:0] rx_sh;
  logic rx_prev;

  assign bit_cycles = spp_pkg::spp_bit_cycles(i_baud_sel);

  // transmit buffer; back-pressure reaches the user through o_tx_ready
  spp_fifo #(.WIDTH(8), .DEPTH(spp_pkg::FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_in_valid(i_tx_valid),
    .o_in_ready(in_ready),
    .i_in_data(i_tx_data),
    .out(txq)
  );

  // pin synchronisers: only stage 1 reads stage 0
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ring_s <= 2'h0;
      rx_s <= {2{spp_pkg::LINE_MARK}};
      hs_s <= 2'h0;
    end else if (i_ce) begin
      ring_s <= {ring_s[0], i_ring};
      rx_s <= {rx_s[0], i_rx_line};
      hs_s <= {hs_s[0], i_clock_handshake_line};
    end
  end

  // registered copy of fifo ready so the output comes from a flop
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_tx_ready <= 1'b0;
    end else if (i_ce) begin
      o_tx_ready <= in_ready;
    end
  end

  // modem enable follows ring
  // ring is driven by the peripheral we only latch on it
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_modem_enable_out <= spp_pkg::RST_MODEM_EN;
    end else if (i_ce) begin
      o_modem_enable_out <= ring_s[1];
    end
  end

  // sync enable asserted
  // held for the whole character in sync or printer mode
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sync_device_enable <= spp_pkg::RST_SYNC_EN;
    end else if (i_ce) begin
      o_sync_device_enable <= (i_sync_mode || i_printer_mode) &&
                              (tx_state != SPP_IDLE || txq.valid);
    end
  end

  // printer handshake gate
  // a low handshake holds the next character; one in flight finishes
  assign txq.ready = (tx_state == SPP_IDLE) &&
                     !(i_printer_mode && !i_sync_mode && !hs_s[1]);

  // transmitter; sync mode drives the clock line, clock rises at mid-bit and data changes at the bit boundary
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_state <= SPP_IDLE;
      tx_cnt <= 20'h00000;
      tx_idx <= 3'h0;
      tx_sh <= 8'h00;
      tx_sync <= 1'b0;
      o_tx_line <= spp_pkg::LINE_MARK;
      o_clock_handshake_line <= 1'b0;
      o_clock_handshake_line_oe <= 1'b0;
    end else if (i_ce) begin
      o_clock_handshake_line_oe <= i_sync_mode;
      case (tx_state)
        SPP_IDLE: begin
          o_tx_line <= spp_pkg::LINE_MARK;
          o_clock_handshake_line <= 1'b0;
          if (txq.valid && txq.ready) begin
            tx_sh <= txq.data;
            tx_cnt <= 20'h00000;
            tx_idx <= 3'h0;
            tx_sync <= i_sync_mode;
            tx_state <= i_sync_mode ? SPP_DATA : SPP_START;
          end
        end
        SPP_START: begin
          o_tx_line <= spp_pkg::LINE_SPACE;
          if (tx_cnt == bit_cycles - 20'h00001) begin
            tx_cnt <= 20'h00000;
            tx_state <= SPP_DATA;
          end else begin
            tx_cnt <= tx_cnt + 20'h00001;
          end
        end
        SPP_DATA: begin
          o_tx_line <= tx_sync ? tx_sh[tx_idx] : ~tx_sh[tx_idx];
          o_clock_handshake_line <= tx_sync && (tx_cnt >= (bit_cycles >> 1));
          if (tx_cnt == bit_cycles - 20'h00001) begin
            tx_cnt <= 20'h00000;
            tx_idx <= tx_idx + 3'h1;
            if (tx_idx == 3'(spp_pkg::DATA_BITS - 1)) begin
              tx_state <= tx_sync ? SPP_IDLE : SPP_STOP;
            end
          end else begin
            tx_cnt <= tx_cnt + 20'h00001;
          end
        end
        SPP_STOP: begin
          o_tx_line <= spp_pkg::LINE_MARK;
          if (tx_cnt == bit_cycles - 20'h00001) begin
            tx_cnt <= 20'h00000;
            tx_state <= SPP_IDLE;
          end else begin
            tx_cnt <= tx_cnt + 20'h00001;
          end
        end
        default: tx_state <= SPP_IDLE;
      endcase
    end
  end

  // receiver: samples at mid-bit after a mark-to-space edge
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_state <= SPP_IDLE;
      rx_cnt <= 20'h00000;
      rx_idx <= 3'h0;
      rx_sh <= 8'h00;
      rx_prev <= spp_pkg::LINE_MARK;
      o_rx_valid <= 1'b0;
      o_rx_data <= 8'h00;
      o_rx_frame_err <= 1'b0;
    end else if (i_ce) begin
      rx_prev <= rx_s[1];
      o_rx_valid <= 1'b0;
      case (rx_state)
        SPP_IDLE: begin
          if (rx_prev == spp_pkg::LINE_MARK && rx_s[1] == spp_pkg::LINE_SPACE) begin
            rx_cnt <= 20'h00000;
            rx_state <= SPP_START;
          end
        end
        SPP_START: begin
          if (rx_cnt == (bit_cycles >> 1)) begin
            rx_cnt <= 20'h00000;
            rx_idx <= 3'h0;
            // glitch shorter than half a bit is dropped
            rx_state <= (rx_s[1] == spp_pkg::LINE_SPACE) ? SPP_DATA : SPP_IDLE;
          end else begin
            rx_cnt <= rx_cnt + 20'h00001;
          end
        end
        SPP_DATA: begin
          if (rx_cnt == bit_cycles - 20'h00001) begin
            rx_cnt <= 20'h00000;
            rx_sh <= {~rx_s[1], rx_sh[7:1]};
            rx_idx <= rx_idx + 3'h1;
            if (rx_idx == 3'(spp_pkg::DATA_BITS - 1)) begin
              rx_state <= SPP_STOP;
            end
          end else begin
            rx_cnt <= rx_cnt + 20'h00001;
          end
        end
        SPP_STOP: begin
          if (rx_cnt == bit_cycles - 20'h00001) begin
            rx_cnt <= 20'h00000;
            o_rx_valid <= 1'b1;
            o_rx_data <= rx_sh;
            o_rx_frame_err <= (rx_s[1] != spp_pkg::LINE_MARK);
            rx_state <= SPP_IDLE;
          end else begin
            rx_cnt <= rx_cnt + 20'h00001;
          end
        end
        default: rx_state <= SPP_IDLE;
      endcase
    end
  end
endmodule // spp_port
`default_nettype wire

// ==== shared/spp_pkg.sv ====
package spp_pkg;
  // clock rate and the selectable bit rates
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned BAUD_300 = 300;
  localparam int unsigned BAUD_1200 = 1200;
  localparam int unsigned BAUD_2400 = 2400;
  localparam int unsigned BAUD_4800 = 4800;
  localparam int unsigned BAUD_9600 = 9600;
  localparam int unsigned BAUD_19200 = 19200;
  localparam int unsigned BAUD_38400 = 38400;
  localparam int unsigned BAUD_115200 = 115200;
  // character framing and transmit buffer depth
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned FIFO_DEPTH = 32;
  // line levels: marking is low on the wire
  localparam logic LINE_MARK = 1'b0;
  localparam logic LINE_SPACE = 1'b1;
  // reset values of the outputs
  localparam logic RST_MODEM_EN = 1'b0;
  localparam logic RST_SYNC_EN = 1'b0;
  // baud select code to clocks per bit, rounded down
  function automatic logic [19:0] spp_bit_cycles(input logic [2:0] sel);
    int unsigned b;
    case (sel)
      3'h0: b = BAUD_300;
      3'h1: b = BAUD_1200;
      3'h2: b = BAUD_2400;
      3'h3: b = BAUD_4800;
      3'h4: b = BAUD_9600;
      3'h5: b = BAUD_19200;
      3'h6: b = BAUD_38400;
      default: b = BAUD_115200;
    endcase
    return 20'(CLK_HZ / b);
  endfunction
endpackage

// ==== shared/spp_stream_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// byte stream between the port core and its transmit buffer
interface spp_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== verilog/spp_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module spp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  spp_stream_if.source out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign out.valid = (count != '0);
  assign out.data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = out.valid && out.ready;

  // storage write, no reset needed on data
  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (i_ce) begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // spp_fifo
`default_nettype wire

// ==== dv/spp_port_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module spp_port_props (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_sync_mode,
  input wire logic i_printer_mode,
  input wire logic i_ring,
  input wire logic o_modem_enable_out,
  input wire logic o_tx_line,
  input wire logic o_clock_handshake_line,
  input wire logic o_clock_handshake_line_oe,
  input wire logic o_rx_valid,
  input wire logic [7:0] o_rx_data,
  input wire logic o_sync_device_enable
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  a_ring_sets_enable: assert property (
    $rose(i_ring) ##1 i_ring [*3] |=> o_modem_enable_out) else $error("enable late");
  a_ring_gone_clears: assert property (
    !i_ring [*5] |-> !o_modem_enable_out) else $error("enable without ring");
  // every async bit lasts far longer than eight clocks at any rate
  a_async_bit_width: assert property (
    $changed(o_tx_line) && !i_sync_mode |=> $stable(o_tx_line) [*7]) else $error("bit short");
  a_sync_drives_pin: assert property (
    i_sync_mode [*2] |-> o_clock_handshake_line_oe) else $error("pin not driven");
  a_pin_released: assert property (
    !i_sync_mode [*2] |-> !o_clock_handshake_line_oe && !o_clock_handshake_line)
    else $error("pin not released");
  a_rx_one_pulse: assert property (
    o_rx_valid |=> !o_rx_valid) else $error("long pulse");
  a_rx_data_held: assert property (
    !o_rx_valid |-> $stable(o_rx_data)) else $error("data moved");
  a_enable_idle_low: assert property (
    (!i_sync_mode && !i_printer_mode) [*3] |-> !o_sync_device_enable) else $error("stray enable");
endmodule // spp_port_props
bind spp_port spp_port_props u_props (.i_clk, .i_rst_b, .i_sync_mode, .i_printer_mode, .i_ring,
  .o_modem_enable_out, .o_tx_line, .o_clock_handshake_line, .o_clock_handshake_line_oe,
  .o_rx_valid, .o_rx_data, .o_sync_device_enable);
`default_nettype wire

// ==== dv/spp_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
module spp_peer (
  input wire logic i_line,
  input wire logic i_sync,
  output logic o_line
);
  // one bit at the fastest rate, 5 ns clocks
  localparam int BIT_NS = 5 * int'(spp_pkg::CLK_HZ / spp_pkg::BAUD_115200);
  logic [7:0] got_q[$];
  logic [7:0] shift;
  logic stop_ok;
  initial o_line = spp_pkg::LINE_MARK;
  // spacing edge opens a frame; sample mid-bit, data inverted
  always @(posedge i_line) begin
    if (!i_sync) begin
      #(BIT_NS / 2);
      for (int i = 0; i < 8; i++) begin
        #(BIT_NS);
        shift[i] = ~i_line;
      end
      #(BIT_NS);
      stop_ok = (i_line == spp_pkg::LINE_MARK);
      got_q.push_back(shift);
    end
  end
  task automatic send(input logic [7:0] d);
    o_line = spp_pkg::LINE_SPACE;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      o_line = ~d[i];
      #(BIT_NS);
    end
    o_line = spp_pkg::LINE_MARK;
    #(BIT_NS);
  endtask
endmodule // spp_peer
`default_nettype wire

// ==== dv/serial_peripheral_port_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_peripheral_port_bench;
  logic i_clk, i_rst_b, i_sync_mode, i_printer_mode, i_tx_valid, i_ring, i_rx_line, hs;
  logic o_tx_ready, o_rx_valid, o_rx_frame_err, o_clock_handshake_line;
  logic o_clock_handshake_line_oe, o_tx_line, o_modem_enable_out, o_sync_device_enable;
  logic [7:0] i_tx_data, o_rx_data, sbits;
  logic [2:0] baud_sel;
  int err_count, cmp_count, cyc, rx_n, s_n;
  // shared pin: the port wins while it drives
  wire logic i_clock_handshake_line = o_clock_handshake_line_oe ? o_clock_handshake_line : hs;
  spp_port dut (.i_clk, .i_rst_b, .i_ce(1'h1), .i_baud_sel(baud_sel), .i_sync_mode, .i_printer_mode,
    .i_tx_valid, .o_tx_ready, .i_tx_data, .o_rx_valid, .o_rx_data, .o_rx_frame_err, .i_ring,
    .i_rx_line, .i_clock_handshake_line, .o_clock_handshake_line, .o_clock_handshake_line_oe,
    .o_tx_line, .o_modem_enable_out, .o_sync_device_enable);
  spp_peer peer (.i_line(o_tx_line), .i_sync(i_sync_mode), .o_line(i_rx_line));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic push(input logic [7:0] d);
    @(negedge i_clk);
    i_tx_valid = 1'h1;
    i_tx_data = d;
    @(negedge i_clk);
    i_tx_valid = 1'h0;
  endtask
  task automatic wait_got;
    for (int i = 0; i < 20000 && peer.got_q.size() == 0; i++) @(negedge i_clk);
  endtask
  // received bytes and sync bits, caught at the ports; hang guard
  // bytes looked at on the falling clock edge, where registered outputs have settled; sync bits on the rising clock line
  always @(negedge i_clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      complete_run();
    end
    if (o_rx_valid) begin
      rx_n++;
      check(o_rx_data, 8'h5A);
      check({7'h0, o_rx_frame_err}, 8'h0);
    end
  end
  always @(posedge o_clock_handshake_line) begin
    if (i_sync_mode) begin
      sbits = {o_tx_line, sbits[7:1]};
      s_n++;
      check({7'h0, o_sync_device_enable}, 8'h1);
    end
  end
  task automatic t_ring;
    i_ring = 1'h1;
    repeat (6) @(negedge i_clk);
    check({7'h0, o_modem_enable_out}, 8'h1);
    i_ring = 1'h0;
    repeat (6) @(negedge i_clk);
    check({7'h0, o_modem_enable_out}, 8'h0);
  endtask
  // both directions at once
  task automatic t_txrx;
    fork
      peer.send(8'h5A);
      push(8'hA5);
    join
    wait_got();
    for (int i = 0; i < 2000 && rx_n == 0; i++) @(negedge i_clk);
    check(peer.got_q.pop_front(), 8'hA5);
    check({6'h0, peer.stop_ok, o_tx_line}, 8'h2);
    check(8'(rx_n), 8'h1);
  endtask
  // handshake low holds the char back, high lets it go
  task automatic t_printer;
    i_printer_mode = 1'h1;
    push(8'hC3);
    repeat (3000) @(negedge i_clk);
    check({6'h0, o_tx_line, o_sync_device_enable}, 8'h1);
    hs = 1'h1;
    wait_got();
    check(peer.got_q.pop_front(), 8'hC3);
    repeat (1736) @(negedge i_clk);
    i_printer_mode = 1'h0;
  endtask
  task automatic t_sync;
    i_sync_mode = 1'h1;
    push(8'h96);
    check({7'h0, o_clock_handshake_line_oe}, 8'h1);
    for (int i = 0; i < 20000 && s_n < 8; i++) @(negedge i_clk);
    check(sbits, 8'h96);
    repeat (1736) @(negedge i_clk);
    i_sync_mode = 1'h0;
  endtask
  // one byte leaves at once, so 33 fit before refusal; reset then flushes
  task automatic t_fill;
    int n = 0;
    while (o_tx_ready === 1'h1 && n < 40) begin
      push(8'(n));
      @(negedge i_clk);
      n++;
    end
    check(8'(n), 8'h21);
    i_rst_b = 1'h0;
    repeat (2) @(negedge i_clk);
    check({6'h0, o_tx_ready, o_tx_line}, 8'h0);
    i_rst_b = 1'h1;
  endtask
  // a slower rate stretches the start bit to its own clock count; frame left in flight
  task automatic t_rate;
    int w = 0;
    baud_sel = 3'h6;
    push(8'hFF);
    for (int i = 0; i < 20 && o_tx_line !== spp_pkg::LINE_SPACE; i++) @(negedge i_clk);
    while (o_tx_line === spp_pkg::LINE_SPACE && w < 6000) begin
      @(negedge i_clk);
      w++;
    end
    check(8'(w), 8'(spp_pkg::CLK_HZ / spp_pkg::BAUD_38400));
    check(8'(w >> 8), 8'((spp_pkg::CLK_HZ / spp_pkg::BAUD_38400) >> 8));
  endtask
  initial begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    {i_rst_b, i_sync_mode, i_printer_mode, i_tx_valid, i_ring, hs} = 6'h0;
    i_tx_data = 8'h0;
    baud_sel = 3'h7;
    repeat (6) @(negedge i_clk);
    i_rst_b = 1'h1;
    t_ring();
    t_txrx();
    t_printer();
    t_sync();
    t_fill();
    t_rate();
    complete_run();
  end
endmodule // serial_peripheral_port_bench
`default_nettype wire
